// *** adc_channel_reader.sv ***
// What this block does
// [R1] switch patterns 0000..0111 pick inputs zero..seven
// [R2] leds show result bits four to eleven
// [R3] full scale lights all, zero lights none
// [R4] four-wire link: select, clock, data out, in
// [R5] serial clock runs at 2 MHz
// [R6] each frame sends next conversion's channel address
// [R7] result belongs to previous frame's address
// [R8] first result after power-up is input zero
// [R9] results are unsigned straight binary
// [R10] frames run back to back, switches sampled each
// [R11] leds update only from the selected channel
`timescale 1ns/1ns
`default_nettype none
module adc_channel_reader
  import adc_reader_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [3:0] channel_select_switch_i,
  input wire logic adc_dout_i,
  output logic adc_cs_n_o,
  output logic adc_sclk_o,
  output logic adc_din_o,
  output logic [7:0] led_o
);
  // every piece of sequencer state in one record
  typedef struct packed {
    fsm_t st; // frame sequencer
    logic [2:0] phase; // position inside one serial clock period
    logic [3:0] bitcnt; // serial clock count inside the frame
    logic [15:0] tx; // outgoing word, msb on the data line
    logic [11:0] rx; // incoming result, oldest bits drop off the top
    logic [2:0] sel; // channel chosen by the switches
    logic [2:0] addr_cur; // channel addressed in this frame
    logic [2:0] addr_prev; // channel addressed in the frame before
    logic first; // no result has come back yet
    logic [7:0] leds; // displayed value
    logic cs_n; // chip select, low during a frame
    logic sclk; // serial clock, idles high
    logic din; // serial data toward the converter
  } state_t;

  state_t cur;
  state_t next_cur;
  adc_sync_if sync_bus ();
  logic [2:0] res_ch; // channel of the result that just finished
  logic match; // that channel is the one on display

  // pins cross into this clock through two flops
  adc_pin_sync u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .adc_dout_i(adc_dout_i),
    .channel_select_switch_i(channel_select_switch_i),
    .sync_o(sync_bus)
  );

  // result attribution by the one-frame pipeline
  always_comb
  begin
    // [R8] power-up result
    res_ch = cur.first ? FIRST_CHANNEL : cur.addr_prev;
    // [R11] selection match
    match = (res_ch == cur.sel);
  end

  // sequencer: idle -> shift sixteen clocks -> done -> gap -> idle
  always_comb
  begin
    next_cur = cur;
    case (cur.st)
      ST_IDLE:
      begin
        // [R10] sample switches per frame
        // [R1] low patterns map straight to channels
        if (!sync_bus.sw[3])
        begin
          next_cur.sel = sync_bus.sw[2:0];
        end
        // patterns 1xxx are undefined, so the last selection is kept
        next_cur.addr_cur = next_cur.sel;
        // [R6] address for next conversion
        next_cur.tx = 16'(next_cur.sel) << ADDR_POS;
        next_cur.din = next_cur.tx[15];
        next_cur.cs_n = 1'b0;
        next_cur.sclk = 1'b0;
        next_cur.phase = 3'h0;
        next_cur.bitcnt = 4'h0;
        next_cur.st = ST_SHIFT;
      end
      ST_SHIFT:
      begin
        // [R5] divide to serial clock
        if (cur.phase == SCLK_LAST)
        begin
          next_cur.phase = 3'h0;
          // sampled late in the high half: the sync delay keeps us before the fall
          next_cur.rx = {cur.rx[10:0], sync_bus.dout};
          next_cur.tx = {cur.tx[14:0], 1'b0};
          next_cur.din = cur.tx[14];
          next_cur.bitcnt = cur.bitcnt + 4'h1;
          if (cur.bitcnt == FRAME_LAST)
          begin
            // [R4] end frame, select high
            next_cur.cs_n = 1'b1;
            next_cur.sclk = 1'b1;
            next_cur.din = 1'b0;
            next_cur.st = ST_DONE;
          end
          else
          begin
            next_cur.sclk = 1'b0;
          end
        end
        else
        begin
          next_cur.phase = cur.phase + 3'h1;
          next_cur.sclk = (next_cur.phase >= SCLK_RISE);
        end
      end
      ST_DONE:
      begin
        // [R2] upper result bits shown
        // [R9] unsigned binary, no conversion
        // [R3] full scale passes through
        if (match)
        begin
          next_cur.leds = cur.rx[11:LED_LSB];
        end
        // [R7] this frame's address owns the next result
        next_cur.addr_prev = cur.addr_cur;
        next_cur.first = 1'b0;
        next_cur.phase = 3'h0;
        next_cur.st = ST_GAP;
      end
      ST_GAP:
      begin
        // quiet time with select high so the converter sees a clean frame edge
        if (cur.phase == GAP_LAST)
        begin
          next_cur.st = ST_IDLE;
        end
        else
        begin
          next_cur.phase = cur.phase + 3'h1;
        end
      end
      default:
      begin
        next_cur.st = ST_IDLE;
        next_cur.cs_n = 1'b1;
        next_cur.sclk = 1'b1;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      // start in the gap: the synchroniser is cleared by reset too, and the first
      // frame must address the real switch setting, not the cleared one
      cur <= '{st: ST_GAP, phase: 3'h0, bitcnt: 4'h0, tx: TX_RESET, rx: 12'h000,
               sel: FIRST_CHANNEL, addr_cur: FIRST_CHANNEL, addr_prev: FIRST_CHANNEL,
               first: 1'b1, leds: LED_RESET, cs_n: 1'b1, sclk: 1'b1, din: 1'b0};
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // all link pins and leds come straight from flops
  assign adc_cs_n_o = cur.cs_n;
  assign adc_sclk_o = cur.sclk;
  assign adc_din_o = cur.din;
  assign led_o = cur.leds;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  // select stays low for the sixteen clocks, then rises
  sequence s_frame;
    ##79 !adc_cs_n_o ##1 adc_cs_n_o;
  endsequence
  // address bits follow two leading zeros, one per serial period
  sequence s_addr_bits;
    !adc_din_o ##5 !adc_din_o ##5 (adc_din_o == cur.addr_cur[2])
      ##5 (adc_din_o == cur.addr_cur[1]) ##5 (adc_din_o == cur.addr_cur[0]);
  endsequence

  property p_frame_len;
    $fell(adc_cs_n_o) |-> s_frame;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong"); // [R4]

  property p_sclk_low;
    $fell(adc_sclk_o) |-> (!adc_sclk_o)[*3] ##1 adc_sclk_o ##1 adc_sclk_o;
  endproperty
  a_sclk_low: assert property (p_sclk_low) else $error("serial clock shape wrong"); // [R5]

  property p_addr_out;
    $fell(adc_cs_n_o) |-> s_addr_bits;
  endproperty
  a_addr_out: assert property (p_addr_out) else $error("channel address wrong"); // [R6]

  property p_sel;
    (cur.st == ST_IDLE && !sync_bus.sw[3]) |=> cur.addr_cur == $past(sync_bus.sw[2:0]);
  endproperty
  a_sel: assert property (p_sel) else $error("switch not taken"); // [R1]

  property p_attrib;
    $rose(adc_cs_n_o) && !cur.first |-> res_ch == $past(cur.addr_cur, 87) ##0 cur.first == 1'b0;
  endproperty
  a_attrib: assert property (p_attrib) else $error("result channel wrong"); // [R7]

  property p_first;
    (cur.st == ST_DONE && cur.first && cur.sel != FIRST_CHANNEL) |=> $stable(led_o);
  endproperty
  a_first: assert property (p_first) else $error("first result not input zero"); // [R8]

  property p_leds;
    (cur.st == ST_DONE && match) |=> led_o == $past(cur.rx[11:4]);
  endproperty
  a_leds: assert property (p_leds) else $error("leds not from result"); // [R2]

  property p_hold;
    (cur.st == ST_DONE && !match) |=> $stable(led_o);
  endproperty
  a_hold: assert property (p_hold) else $error("leds changed for other channel"); // [R11]

  property p_full;
    (cur.st == ST_DONE && match && cur.rx == 12'hfff) |=> led_o == 8'hff;
  endproperty
  a_full: assert property (p_full) else $error("full scale not all lit"); // [R3]

  property p_back_to_back;
    $rose(adc_cs_n_o) |-> ##7 $fell(adc_cs_n_o);
  endproperty
  a_back_to_back: assert property (p_back_to_back) else $error("frames not back to back"); // [R10]
endmodule
`default_nettype wire

// *** adc_reader_pkg.sv ***
package adc_reader_pkg;
  // clock figures, in hertz
  localparam int SYS_CLK_HZ = 10_000_000;
  localparam int SPI_CLK_HZ = 2_000_000;
  // serial clock period in system cycles, and how many of them stay low
  localparam int SCLK_DIV = SYS_CLK_HZ / SPI_CLK_HZ;
  localparam logic [2:0] SCLK_LAST = 3'(SCLK_DIV - 1);
  localparam logic [2:0] SCLK_RISE = 3'(SCLK_DIV - 2);
  // one frame is sixteen serial clocks
  localparam logic [3:0] FRAME_LAST = 4'hf;
  // channel address position inside the outgoing word
  localparam int ADDR_POS = 11;
  // result bits that reach the leds
  localparam int LED_LSB = 4;
  // idle cycles with chip select high between frames
  localparam logic [2:0] GAP_LAST = 3'h4;
  // channel that the first result after power-up belongs to
  localparam logic [2:0] FIRST_CHANNEL = 3'h0;
  // reset values
  localparam logic [7:0] LED_RESET = 8'h00;
  localparam logic [15:0] TX_RESET = 16'h0000;

  // gray-coded frame sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE = 2'b11,
    ST_GAP = 2'b10
  } fsm_t;
endpackage

// *** adc_sync_if.sv ***
`timescale 1ns/1ns
`default_nettype none
// synchronised pin levels passed from the input stage to the sequencer
interface adc_sync_if;
  logic dout;
  logic [3:0] sw;
  modport src (output dout, output sw);
  modport dst (input dout, input sw);
endinterface
`default_nettype wire

// *** adc_pin_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
// two-stage synchroniser for the converter data line and the switches
module adc_pin_sync
  import adc_reader_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic adc_dout_i,
  input wire logic [3:0] channel_select_switch_i,
  adc_sync_if.src sync_o
);
  typedef struct packed {
    logic [4:0] meta; // first stage, read only by the second
    logic [4:0] stable; // second stage, safe to use
  } sync_state_t;

  sync_state_t cur;
  sync_state_t next_cur;

  // shift pins through both stages
  always_comb
  begin
    next_cur = cur;
    next_cur.meta = {channel_select_switch_i, adc_dout_i};
    next_cur.stable = cur.meta;
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign sync_o.dout = cur.stable[0];
  assign sync_o.sw = cur.stable[4:1];
endmodule
`default_nettype wire

// *** adc_converter_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// behavioural serial converter on the far side of the link
module adc_converter_model
(
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  output logic dout_o
);
  // analog level per input, set by the bench
  logic [11:0] level [8];
  // channel of the conversion now under way
  logic [2:0] conv_ch = 3'h0;
  logic [15:0] rx_word = 16'h0000;
  logic [15:0] tx_word = 16'h0000;
  int bit_n = 0;
  initial dout_o = 1'b0;
  // address bits taken on sclk rise
  always @(posedge sclk_i)
    if (!cs_n_i)
      rx_word = {rx_word[14:0], din_i};
  // straight binary result shifted on sclk fall
  always @(negedge sclk_i)
  begin
    // settle past the edge where select falls with sclk
    #1;
    if (!cs_n_i && bit_n < 16)
    begin
      if (bit_n == 0)
        tx_word = {4'h0, level[conv_ch]};
      dout_o = tx_word[15 - bit_n];
      bit_n++;
    end
  end
  // next result belongs to this frame's address
  always @(posedge cs_n_i)
  begin
    bit_n = 0;
    conv_ch = rx_word[13:11];
    // released line: no pull, so show the inverse
    dout_o = ~dout_o;
  end
endmodule
`default_nettype wire

// *** adc_channel_reader_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module adc_channel_reader_test;
  import adc_reader_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] sw = 4'h3;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic [7:0] led;
  int err_total = 0;
  int compares = 0;
  always #50 mclk = ~mclk;
  adc_channel_reader dut (.mclk_i(mclk), .rst_i(rst), .channel_select_switch_i(sw),
    .adc_dout_i(dout), .adc_cs_n_o(cs_n), .adc_sclk_o(sclk), .adc_din_o(din), .led_o(led));
  adc_converter_model conv (.cs_n_i(cs_n), .sclk_i(sclk), .din_i(din), .dout_o(dout));
  // compare and report at once
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // wait n frame ends, bounded; leds settle one cycle after
  task automatic frames(input int n);
    int seen;
    logic was;
    seen = 0;
    was = cs_n;
    for (int k = 0; k < 100 * n && seen < n; k++)
    begin
      @(posedge mclk);
      #1;
      if (cs_n === 1'b1 && was === 1'b0)
        seen++;
      was = cs_n;
    end
    if (seen < n)
    begin
      chk("frame end", 16'(n), 16'(seen));
      tally_and_finish();
    end
    repeat (3) @(posedge mclk);
    #1;
  endtask
  // first result is input zero, not the selected three
  task automatic t_first();
    frames(1);
    chk("led first", 16'h0000, {8'h00, led});
    frames(1);
    chk("led second", {8'h00, conv.level[3][11:4]}, {8'h00, led});
    $display("t_first done");
  endtask
  // every pattern 0000..0111, with the one-frame lag after each change
  task automatic t_channels();
    logic [7:0] shown;
    shown = conv.level[3][11:4];
    for (int c = 0; c < 8; c++)
    begin
      sw = 4'(c);
      frames(1);
      chk("led hold", {8'h00, shown}, {8'h00, led});
      frames(2);
      shown = conv.level[c][11:4];
      chk("led chan", {8'h00, shown}, {8'h00, led});
    end
    $display("t_channels done");
  endtask
  // 1xxx keeps channel seven; extremes of scale
  task automatic t_refused();
    sw = 4'ha;
    conv.level[7] = 12'hfff;
    frames(3);
    chk("led full", 16'h00ff, {8'h00, led});
    conv.level[7] = 12'h000;
    frames(2);
    chk("led zero", 16'h0000, {8'h00, led});
    conv.level[7] = 12'h80f;
    frames(2);
    chk("led mid", 16'h0080, {8'h00, led});
    $display("t_refused done");
  endtask
  // one frame on the wire: length, clocks, address word
  task automatic t_frame();
    int low;
    int rises;
    logic [15:0] word;
    logic was;
    low = 0;
    rises = 0;
    word = 16'h0000;
    was = 1'b1;
    for (int k = 0; k < 200 && cs_n !== 1'b0; k++)
    begin
      @(posedge mclk);
      #1;
    end
    while (cs_n === 1'b0 && low < 200)
    begin
      if (sclk === 1'b1 && was === 1'b0)
      begin
        rises++;
        word = {word[14:0], din};
      end
      was = sclk;
      low++;
      @(posedge mclk);
      #1;
    end
    chk("select low", 16'd80, 16'(low));
    chk("sclk rises", 16'd16, 16'(rises));
    chk("din word", {2'b00, 3'h7, 11'h000}, word);
    chk("sclk idle", 16'h0001, {15'h0000, sclk});
    $display("t_frame done");
  endtask
  initial
  begin
    for (int i = 0; i < 8; i++)
      conv.level[i] = 12'h0a5 + 12'h1f0 * 12'(i);
    repeat (10) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_first();
    t_channels();
    t_refused();
    t_frame();
    tally_and_finish();
  end
endmodule
`default_nettype wire
